// >>> core/sirq_bank_pkg.sv
// constants and carrier types for the serial irq enable bank
package sirq_bank_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] CTRL1_OFFSET  = 4'h0;
    localparam logic [ADDR_W-1:0] MODE_OFFSET   = 4'h1;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h2;
    localparam logic [ADDR_W-1:0] MASK_OFFSET   = 4'h3;
    localparam logic [ADDR_W-1:0] REQ_OFFSET    = 4'h4;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int IRQ11_ON_CH3_BIT = 7;
    localparam int IRQ10_ON_CH3_BIT = 6;
    localparam int IRQ9_ON_CH3_BIT  = 5;
    localparam int IRQ6_ON_CH3_BIT  = 4;
    localparam int IRQ11_ON_CH2_BIT = 3;
    localparam int DIRECT_SEL_BIT   = 0;
    localparam int EV_REQ_RISE_BIT  = 0;
    localparam int EV_AUTO_CLR_BIT  = 1;
    localparam int EV_LPC_RST_BIT   = 2;
    localparam int EV_W             = 3;

    ////////////////////////////////////////////////////////////////////////
    // reset values and masks
    localparam logic [DATA_W-1:0] CTRL1_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] ENABLE_MASK  = 8'hF8;
    localparam logic              MODE_RESET   = 1'b0;
    localparam logic [EV_W-1:0]   STATUS_RESET = 3'h0;
    localparam logic [EV_W-1:0]   MASK_RESET   = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_type;

    typedef struct packed {
        logic ch3a_output_full_flag;
        logic ch2_output_full_flag;
    } out_full_type;

    typedef struct packed {
        logic irq11;
        logic irq10;
        logic irq9;
        logic irq6;
    } host_irq_req_type;

endpackage

// >>> core/serial_irq_enable_bank.sv
// serial irq enable bank: host irq request enables, direct mode, event irq
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module serial_irq_enable_bank
    import sirq_bank_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             arst_n_in,
    // register port
    input  wire reg_req_type      reg_req_in,
    output logic [DATA_W-1:0]     rd_data_out,
    // output buffer flags, same clock
    input  wire out_full_type     out_full_in,
    // lpc pins
    input  wire logic             lpc_clk_in,
    input  wire logic             lpc_hw_reset_n_in,
    input  wire logic             lpc_sw_reset_in,
    // host requests and local interrupt
    output host_irq_req_type      host_irq_req_out,
    output logic                  irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic                  rst_s1_reg;
    logic                  rst_n_reg;

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic                  lpc_clk_s1_reg;
    logic                  lpc_clk_s2_reg;
    logic                  lpc_clk_s3_reg;
    logic                  hw_rst_n_s1_reg;
    logic                  hw_rst_n_s2_reg;
    logic                  sw_rst_s1_reg;
    logic                  sw_rst_s2_reg;
    logic                  lpc_edge;
    logic                  lpc_reset_active;

    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            lpc_clk_s1_reg  <= 1'b0;
            lpc_clk_s2_reg  <= 1'b0;
            lpc_clk_s3_reg  <= 1'b0;
            hw_rst_n_s1_reg <= 1'b1;
            hw_rst_n_s2_reg <= 1'b1;
            sw_rst_s1_reg   <= 1'b0;
            sw_rst_s2_reg   <= 1'b0;
        end
        else
        begin
            lpc_clk_s1_reg  <= lpc_clk_in;
            lpc_clk_s2_reg  <= lpc_clk_s1_reg;
            lpc_clk_s3_reg  <= lpc_clk_s2_reg;
            hw_rst_n_s1_reg <= lpc_hw_reset_n_in;
            hw_rst_n_s2_reg <= hw_rst_n_s1_reg;
            sw_rst_s1_reg   <= lpc_sw_reset_in;
            sw_rst_s2_reg   <= sw_rst_s1_reg;
        end
    end

    assign lpc_edge         = lpc_clk_s2_reg & ~lpc_clk_s3_reg;
    assign lpc_reset_active = ~hw_rst_n_s2_reg | sw_rst_s2_reg;

    ////////////////////////////////////////////////////////////////////////
    // decode and flag edges
    logic                  wr_ctrl;
    logic                  rd_ctrl;
    logic                  ch3_fall;
    logic                  ch2_fall;
    out_full_type          flags_prev_reg;
    logic [DATA_W-1:0]     ctrl_reg;
    logic [DATA_W-1:0]     ctrl_next;
    logic [DATA_W-1:0]     armed_reg;
    logic                  direct_reg;

    assign wr_ctrl  = reg_req_in.wr && (reg_req_in.addr == CTRL1_OFFSET);
    assign rd_ctrl  = reg_req_in.rd && (reg_req_in.addr == CTRL1_OFFSET);
    assign ch3_fall = flags_prev_reg.ch3a_output_full_flag & ~out_full_in.ch3a_output_full_flag;
    assign ch2_fall = flags_prev_reg.ch2_output_full_flag & ~out_full_in.ch2_output_full_flag;

    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            flags_prev_reg <= '0;
        else
            flags_prev_reg <= out_full_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // enable register
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (!direct_reg)
        begin
            if (ch3_fall)
                ctrl_next[IRQ11_ON_CH3_BIT:IRQ6_ON_CH3_BIT] = 4'h0;
            if (ch2_fall)
                ctrl_next[IRQ11_ON_CH2_BIT] = 1'b0;
        end
        if (wr_ctrl)
            ctrl_next = ((ctrl_next & reg_req_in.wdata) | (reg_req_in.wdata & armed_reg)) & ENABLE_MASK;
        if (lpc_reset_active)
            ctrl_next = CTRL1_RESET;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            ctrl_reg <= CTRL1_RESET;
        else
            ctrl_reg <= ctrl_next;
    end

    // a read of zero arms the bit for one following write
    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            armed_reg <= CTRL1_RESET;
        else if (rd_ctrl)
            armed_reg <= ~ctrl_reg & ENABLE_MASK;
        else if (wr_ctrl)
            armed_reg <= CTRL1_RESET;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            direct_reg <= MODE_RESET;
        else if (reg_req_in.wr && (reg_req_in.addr == MODE_OFFSET))
            direct_reg <= reg_req_in.wdata[DIRECT_SEL_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // host request formation
    function automatic host_irq_req_type req_of(input logic [DATA_W-1:0] en,
                                                input logic direct,
                                                input out_full_type fl);
        logic c3;
        logic c2;
        c3 = direct | fl.ch3a_output_full_flag;
        c2 = direct | fl.ch2_output_full_flag;
        req_of.irq11 = (en[IRQ11_ON_CH3_BIT] & c3) | (en[IRQ11_ON_CH2_BIT] & c2);
        req_of.irq10 = en[IRQ10_ON_CH3_BIT] & c3;
        req_of.irq9  = en[IRQ9_ON_CH3_BIT] & c3;
        req_of.irq6  = en[IRQ6_ON_CH3_BIT] & c3;
    endfunction

    host_irq_req_type      req_now;
    host_irq_req_type      req_prev_reg;
    host_irq_req_type      host_req_reg;

    assign req_now = req_of(ctrl_reg, direct_reg, out_full_in);

    // held steady between lpc clock edges for the frame logic
    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            host_req_reg <= '0;
        else if (lpc_edge)
            host_req_reg <= req_now;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            req_prev_reg <= '0;
        else
            req_prev_reg <= req_now;
    end

    assign host_irq_req_out = host_req_reg;

    ////////////////////////////////////////////////////////////////////////
    // event status, mask, interrupt
    logic [EV_W-1:0]       events;
    logic [EV_W-1:0]       status_reg;
    logic [EV_W-1:0]       mask_reg;
    logic [EV_W-1:0]       w1c;

    always_comb
    begin
        events                  = '0;
        events[EV_REQ_RISE_BIT] = |(req_now & ~req_prev_reg);
        events[EV_AUTO_CLR_BIT] = !direct_reg && !lpc_reset_active
                                  && ((ch3_fall && |ctrl_reg[IRQ11_ON_CH3_BIT:IRQ6_ON_CH3_BIT])
                                  || (ch2_fall && ctrl_reg[IRQ11_ON_CH2_BIT]));
        events[EV_LPC_RST_BIT]  = lpc_reset_active && |ctrl_reg;
    end

    assign w1c = (reg_req_in.wr && (reg_req_in.addr == STATUS_OFFSET)) ? reg_req_in.wdata[EV_W-1:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            status_reg <= STATUS_RESET;
        else
            status_reg <= (status_reg & ~w1c) | events;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            mask_reg <= MASK_RESET;
        else if (reg_req_in.wr && (reg_req_in.addr == MASK_OFFSET))
            mask_reg <= reg_req_in.wdata[EV_W-1:0];
    end

    assign irq_out = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // read data, valid only the cycle after the strobe
    logic [DATA_W-1:0]     rd_data_reg;
    logic [DATA_W-1:0]     rd_mux;

    always_comb
    begin
        rd_mux = '0;
        unique case (reg_req_in.addr)
            CTRL1_OFFSET:  rd_mux = ctrl_reg;
            MODE_OFFSET:   rd_mux[DIRECT_SEL_BIT] = direct_reg;
            STATUS_OFFSET: rd_mux[EV_W-1:0] = status_reg;
            MASK_OFFSET:   rd_mux[EV_W-1:0] = mask_reg;
            REQ_OFFSET:    rd_mux[3:0] = host_req_reg;
            default:       rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            rd_data_reg <= '0;
        else
            rd_data_reg <= reg_req_in.rd ? rd_mux : '0;
    end

    assign rd_data_out = rd_data_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_reg);

    lpc_reset_clears_a: assert property (lpc_reset_active |=> ctrl_reg == CTRL1_RESET)
        else $error("enables not cleared by lpc reset");

    write_zero_clears_a: assert property (wr_ctrl && !reg_req_in.wdata[IRQ11_ON_CH3_BIT]
                                          |=> !ctrl_reg[IRQ11_ON_CH3_BIT])
        else $error("write of zero did not clear enable");

    set_after_read_a: assert property ($rose(ctrl_reg[IRQ10_ON_CH3_BIT])
                                       |-> $past(wr_ctrl && armed_reg[IRQ10_ON_CH3_BIT]
                                                 && reg_req_in.wdata[IRQ10_ON_CH3_BIT]))
        else $error("enable set without prior read of zero");

    flag_clear_a: assert property (!direct_reg && ch2_fall && !wr_ctrl
                                   |=> !ctrl_reg[IRQ11_ON_CH2_BIT])
        else $error("flag clear did not clear enable");

    irq11_ch3_a: assert property (lpc_edge && !direct_reg && ctrl_reg[IRQ11_ON_CH3_BIT]
                                  && out_full_in.ch3a_output_full_flag |=> host_irq_req_out.irq11)
        else $error("irq11 not requested from ch3a");

    irq10_off_a: assert property (lpc_edge && !ctrl_reg[IRQ10_ON_CH3_BIT]
                                  |=> !host_irq_req_out.irq10 [*1] ##1 1)
        else $error("irq10 requested while disabled");

    irq9_direct_a: assert property (lpc_edge && direct_reg && ctrl_reg[IRQ9_ON_CH3_BIT]
                                    |=> host_irq_req_out.irq9)
        else $error("direct mode irq9 not requested");

    irq6_hold_a: assert property (!lpc_edge |=> $stable(host_irq_req_out.irq6))
        else $error("irq6 request moved between lpc edges");

    irq11_ch2_a: assert property (lpc_edge && ctrl_reg[IRQ11_ON_CH2_BIT]
                                  && (direct_reg || out_full_in.ch2_output_full_flag)
                                  |=> host_irq_req_out.irq11)
        else $error("irq11 not requested from ch2");

    read_one_cycle_a: assert property (!reg_req_in.rd |=> rd_data_out == '0)
        else $error("read data outside read cycle");

    cover_direct_c: cover property (direct_reg && lpc_edge && |req_now);
    cover_auto_clr_c: cover property (events[EV_AUTO_CLR_BIT]);
    cover_arm_set_c: cover property (rd_ctrl ##[1:4] wr_ctrl ##1 $rose(ctrl_reg[IRQ11_ON_CH3_BIT]));
    cover_irq_c: cover property ($rose(irq_out));

endmodule

// >>> verification/lpc_host_model.sv
// lpc host side model: link clock and lpc reset pins
`timescale 1ns/1ps

module lpc_host_model
(
    // link clock run and reset control from the bench
    input  wire logic run_in,
    input  wire logic hw_rst_in,
    input  wire logic sw_rst_in,
    // pins toward the device
    output logic      lpc_clk_out,
    output logic      lpc_hw_reset_n_out,
    output logic      lpc_sw_reset_out
);
    // odd start offset keeps the link phase apart from the system clock
    initial
    begin
        lpc_clk_out = 1'b0;
        #7;
        forever
        begin
            #80;
            lpc_clk_out = run_in ? ~lpc_clk_out : 1'b0;
        end
    end

    assign lpc_hw_reset_n_out = ~hw_rst_in;
    assign lpc_sw_reset_out   = sw_rst_in;
endmodule

// >>> verification/serial_irq_enable_bank_tb_top.sv
// testbench for the serial irq enable bank
`timescale 1ns/1ps

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module serial_irq_enable_bank_tb_top;
    import sirq_bank_pkg::*;

    logic             clk_sys_in = 1'b0;
    logic             arst_n_in = 1'b0;
    reg_req_type      req = '0;
    out_full_type     fl = '0;
    logic [7:0]       rdat;
    host_irq_req_type hreq;
    logic             irq;
    logic             lclk;
    logic             hw_n;
    logic             sw;
    logic             run = 1'b0;
    logic             hw_rst = 1'b0;
    logic             sw_rst = 1'b0;
    int               failures = 0;
    int               checked = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    serial_irq_enable_bank i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_req_in(req),
        .rd_data_out(rdat), .out_full_in(fl), .lpc_clk_in(lclk), .lpc_hw_reset_n_in(hw_n),
        .lpc_sw_reset_in(sw), .host_irq_req_out(hreq), .irq_out(irq));

    lpc_host_model i_host (.run_in(run), .hw_rst_in(hw_rst), .sw_rst_in(sw_rst),
        .lpc_clk_out(lclk), .lpc_hw_reset_n_out(hw_n), .lpc_sw_reset_out(sw));

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        req.rd <= 1'b0;
        @(negedge clk_sys_in);
        `CHK(rdat, e)
    endtask

    // twenty system clocks, two and a half link periods, cover the detect and update latency
    task automatic chk_req(input logic [3:0] e);
        repeat (20) @(posedge clk_sys_in);
        `CHK(hreq, e)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        reg_rd(CTRL1_OFFSET, CTRL1_RESET);
        reg_rd(MODE_OFFSET, 8'h00);
        reg_rd(STATUS_OFFSET, 8'h00);
        reg_rd(4'hF, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_arm();
        reg_wr(CTRL1_OFFSET, 8'h00);
        reg_wr(CTRL1_OFFSET, 8'h80);
        reg_rd(CTRL1_OFFSET, 8'h00);
        reg_wr(CTRL1_OFFSET, 8'hF8);
        reg_rd(CTRL1_OFFSET, 8'hF8);
        reg_wr(CTRL1_OFFSET, 8'h70);
        reg_rd(CTRL1_OFFSET, 8'h70);
        $display("test arm done");
    endtask

    task automatic t_normal();
        run <= 1'b1;
        reg_rd(CTRL1_OFFSET, 8'h70);
        reg_wr(CTRL1_OFFSET, 8'hF8);
        reg_rd(CTRL1_OFFSET, 8'hF8);
        chk_req(4'b0000);
        fl.ch2_output_full_flag <= 1'b1;
        chk_req(4'b1000);
        fl.ch3a_output_full_flag <= 1'b1;
        chk_req(4'b1111);
        fl.ch2_output_full_flag <= 1'b0;
        reg_rd(CTRL1_OFFSET, 8'hF0);
        reg_wr(MASK_OFFSET, 8'h02);
        @(negedge clk_sys_in);
        `CHK(irq, 1'b1)
        reg_wr(STATUS_OFFSET, 8'h07);
        @(negedge clk_sys_in);
        `CHK(irq, 1'b0)
        @(posedge clk_sys_in);
        fl.ch3a_output_full_flag <= 1'b0;
        chk_req(4'b0000);
        reg_rd(CTRL1_OFFSET, 8'h00);
        $display("test normal done");
    endtask

    task automatic t_direct();
        reg_wr(MODE_OFFSET, 8'h01);
        reg_rd(CTRL1_OFFSET, 8'h00);
        reg_wr(CTRL1_OFFSET, 8'hF8);
        chk_req(4'b1111);
        reg_rd(REQ_OFFSET, 8'h0F);
        reg_wr(STATUS_OFFSET, 8'h07);
        hw_rst <= 1'b1;
        // two sync stages plus the clearing edge
        repeat (3) @(posedge clk_sys_in);
        reg_rd(CTRL1_OFFSET, 8'h00);
        repeat (8) @(posedge clk_sys_in);
        reg_rd(CTRL1_OFFSET, 8'h00);
        @(posedge clk_sys_in);
        hw_rst <= 1'b0;
        reg_rd(STATUS_OFFSET, 8'h04);
        repeat (4) @(posedge clk_sys_in);
        reg_rd(CTRL1_OFFSET, 8'h00);
        reg_wr(CTRL1_OFFSET, 8'h08);
        sw_rst <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        sw_rst <= 1'b0;
        reg_rd(CTRL1_OFFSET, 8'h00);
        run <= 1'b0;
        $display("test direct done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        t_reset();
        t_arm();
        t_normal();
        t_direct();
        print_verdict();
    end

    initial
    begin
        #2ms;
        failures++;
        print_verdict();
    end
endmodule
